// ### hdl/rlp_cfg.svh
`ifndef RLP_CFG_SVH
`define RLP_CFG_SVH
// ==========================================================
// Register byte addresses (chosen map, one word each)
`define RLP_ADDR_CTRL      12'h000
`define RLP_ADDR_DUTY0     12'h004
`define RLP_ADDR_BUFA      12'h100
`define RLP_ADDR_BUFB      12'h200
`define RLP_ADDR_STATUS    12'h040
`define RLP_HSIZE_WORD     3'h2
// ==========================================================
// Control fields
`define RLP_BIT_ENABLE     7
`define RLP_BIT_UNUSED     6
`define RLP_DIV_HI         5
`define RLP_DIV_LO         4
`define RLP_BIT_BUFSEL     3
`define RLP_BIT_POL        2
`define RLP_BIT_COMCNT     1
`define RLP_BIT_SCAN       0
`define RLP_CTRL_RESET     8'h00
`define RLP_CTRL_LOCKMASK  8'h37
// ==========================================================
// Geometry and timing
`define RLP_NUM_CH         15
`define RLP_SCAN_CH        12
`define RLP_NUM_COM        4
`define RLP_BUF_WORDS      64
`define RLP_LOAD_TICKS     4
`define RLP_DUTY_RESET     8'h00
`define RLP_CNT_LAST       8'hff
`endif

// ### hdl/rlp_clock_divider.sv
`timescale 1ns/1ps
`include "rlp_cfg.svh"
// ==========================================================
// PWM clock tick generator
module rlp_clock_divider (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // Control
  input  wire logic       run,
  input  wire logic [1:0] divide,
  // Outputs
  output logic            pwm_clock,
  output logic            tick
);
  logic [1:0] phase_reg;

  // Tick marks the rising PWM clock edge; divide by code plus one.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      phase_reg <= 2'h0;
    end else if (!run || phase_reg >= divide) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  assign tick = run && (phase_reg == 2'h0);

  // By three the clock is high for two phases and low for one.
  always_comb begin
    unique case (divide)
      2'b00:   pwm_clock = run;
      2'b01:   pwm_clock = (phase_reg == 2'h0);
      2'b10:   pwm_clock = (phase_reg != 2'h2);
      2'b11:   pwm_clock = (phase_reg < 2'h2);
    endcase
  end
endmodule : rlp_clock_divider

// ### hdl/rlp_pkg.sv
package rlp_pkg;
  typedef struct packed {
    logic       enable;
    logic [1:0] divide;
    logic       buf_sel;
    logic       polarity;
    logic       com_four;
    logic       scan;
  } rlp_ctrl_t;
  typedef enum logic [1:0] {
    RLP_IDLE,
    RLP_LOAD,
    RLP_RUN
  } rlp_scan_state_t;
endpackage : rlp_pkg

// ### hdl/rlp_pwm_control.sv
// What this block does
// - Disabled: commons inactive, channels 0 to 11 held at one.
// - Control bit 6 is unimplemented and reads zero.
// - Two-bit divide code selects PWM clock divide by one to four.
// - Divide by three: PWM clock high two periods, low one.
// - Buffer select zero scans buffer A, one scans buffer B.
// - Buffer select is sampled at frame end while scanning, and followed every cycle while not scanning.
// - Software access to the buffer being scanned is blocked.
// - Polarity zero makes commons active low, one active high.
// - Direct mode keeps every common line inactive.
// - Disabled: commons high for polarity zero, low for one.
// - Count select zero scans three commons, one scans four.
// - Mode bit zero is direct drive, one is scanning.
// - Scanning makes duty registers 0 to 11 read-only.
// - Scanning leaves duty registers 12 to 14 without effect.
// - Duty index 3k+c drives LED k colour c.
// - Period is 256 PWM clocks; duty updates do not restart it.
// - Scanning loads twelve duty bytes per common line.
// - Frame uses 36 or 48 buffer bytes; others unused.
// - Scanning floats outputs of duty registers 12 to 14.
`timescale 1ns/1ps
`include "rlp_cfg.svh"
module rlp_pwm_control (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // LED pins
  output logic [14:0]      led_channel_outputs,
  output logic [14:0]      led_channel_oe_n,
  output logic [3:0]       common_drive_lines,
  output logic             pwm_clock
);
  import rlp_pkg::*;

  // ==========================================================
  // Registers
  rlp_ctrl_t       ctrl_reg;
  logic [7:0]      duty_reg [`RLP_NUM_CH];
  logic [7:0]      buf_a_reg [`RLP_BUF_WORDS];
  logic [7:0]      buf_b_reg [`RLP_BUF_WORDS];
  logic [7:0]      count_reg;
  rlp_scan_state_t state_reg;
  logic            frame_buf_reg;
  logic [1:0]      com_reg;
  logic [3:0]      load_idx_reg;
  logic [1:0]      load_tick_reg;
  logic            wr_pend_reg;
  logic [11:0]     wr_addr_reg;
  logic [31:0]     rdata_reg;
  logic            tick;
  logic            scanning;
  logic            in_load;
  logic [7:0]      load_byte;
  logic [5:0]      load_base;
  logic [7:0]      ctrl_rd;
  logic            take;

  assign scanning  = ctrl_reg.enable && ctrl_reg.scan;
  assign in_load   = (state_reg == RLP_LOAD);
  // Narrow transfers are ignored, since each register is one aligned word.
  assign take      = hready && hsel && htrans[1] && (hsize == `RLP_HSIZE_WORD);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;
  assign ctrl_rd   = {ctrl_reg.enable, 1'b0, ctrl_reg.divide, ctrl_reg.buf_sel,
                      ctrl_reg.polarity, ctrl_reg.com_four, ctrl_reg.scan};

  rlp_clock_divider u_div (
    .clock     (clock),
    .reset     (reset),
    .run       (ctrl_reg.enable),
    .divide    (ctrl_reg.divide),
    .pwm_clock (pwm_clock),
    .tick      (tick)
  );

  // ==========================================================
  // AHB-Lite address phase capture; zero wait states.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
    end else if (hready) begin
      wr_pend_reg <= take && hwrite;
      wr_addr_reg <= haddr;
    end
  end

  // Blocked buffer lines read zero and ignore writes.
  function automatic logic buf_blocked(input logic is_b);
    buf_blocked = scanning && (frame_buf_reg == is_b);
  endfunction : buf_blocked

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rdata_reg <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      rdata_reg <= 32'h0000_0000;
      if (haddr == `RLP_ADDR_CTRL) begin
        rdata_reg <= {24'h00_0000, ctrl_rd};
      end else if (haddr == `RLP_ADDR_STATUS) begin
        rdata_reg <= {24'h00_0000, count_reg};
      end else if (haddr >= `RLP_ADDR_DUTY0 &&
                   haddr < `RLP_ADDR_DUTY0 + 12'(4 * `RLP_NUM_CH)) begin
        rdata_reg <= {24'h00_0000, duty_reg[4'((haddr - `RLP_ADDR_DUTY0) >> 2)]};
      end else if (haddr[11:8] == `RLP_ADDR_BUFA >> 8 && !buf_blocked(1'b0)) begin
        rdata_reg <= {24'h00_0000, buf_a_reg[haddr[7:2]]};
      end else if (haddr[11:8] == `RLP_ADDR_BUFB >> 8 && !buf_blocked(1'b1)) begin
        rdata_reg <= {24'h00_0000, buf_b_reg[haddr[7:2]]};
      end
    end
  end

  // ==========================================================
  // Control register. Locked fields keep their value while enabled.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_reg <= rlp_ctrl_t'(7'h00);
    end else if (wr_pend_reg && wr_addr_reg == `RLP_ADDR_CTRL) begin
      ctrl_reg.enable  <= hwdata[`RLP_BIT_ENABLE];
      ctrl_reg.buf_sel <= hwdata[`RLP_BIT_BUFSEL];
      if (!ctrl_reg.enable) begin
        ctrl_reg.divide   <= hwdata[`RLP_DIV_HI:`RLP_DIV_LO];
        ctrl_reg.polarity <= hwdata[`RLP_BIT_POL];
        ctrl_reg.com_four <= hwdata[`RLP_BIT_COMCNT];
        ctrl_reg.scan     <= hwdata[`RLP_BIT_SCAN];
      end
    end
  end

  // ==========================================================
  // RAM buffers, software side.
  always_ff @(posedge clock) begin
    if (wr_pend_reg && wr_addr_reg[11:8] == `RLP_ADDR_BUFA >> 8 && !buf_blocked(1'b0)) begin
      buf_a_reg[wr_addr_reg[7:2]] <= hwdata[7:0];
    end
    if (wr_pend_reg && wr_addr_reg[11:8] == `RLP_ADDR_BUFB >> 8 && !buf_blocked(1'b1)) begin
      buf_b_reg[wr_addr_reg[7:2]] <= hwdata[7:0];
    end
  end

  // ==========================================================
  // Period counter; 256 PWM clocks, held at zero while disabled or loading.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count_reg <= 8'h00;
    end else if (!ctrl_reg.enable || in_load) begin
      count_reg <= 8'h00;
    end else if (tick) begin
      count_reg <= count_reg + 8'h01;
    end
  end

  // ==========================================================
  // Scan sequencer: load twelve bytes, then run one period per common.
  assign load_base = 6'(com_reg * `RLP_SCAN_CH);
  assign load_byte = frame_buf_reg ? buf_b_reg[load_base + 6'(load_idx_reg)]
                                   : buf_a_reg[load_base + 6'(load_idx_reg)];

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_reg     <= RLP_IDLE;
      frame_buf_reg <= 1'b0;
      com_reg       <= 2'h0;
      load_idx_reg  <= 4'h0;
      load_tick_reg <= 2'h0;
    end else if (!scanning) begin
      state_reg     <= RLP_IDLE;
      com_reg       <= 2'h0;
      frame_buf_reg <= ctrl_reg.buf_sel;
    end else begin
      unique case (state_reg)
        RLP_IDLE: begin
          state_reg     <= RLP_LOAD;
          load_idx_reg  <= 4'h0;
          load_tick_reg <= 2'h0;
        end
        RLP_LOAD: begin
          // Four PWM clocks per byte keeps the load time as the hardware expects.
          if (tick) begin
            load_tick_reg <= load_tick_reg + 2'h1;
            if (load_tick_reg == 2'(`RLP_LOAD_TICKS - 1)) begin
              if (load_idx_reg == 4'(`RLP_SCAN_CH - 1)) begin
                state_reg <= RLP_RUN;
              end
              load_idx_reg <= load_idx_reg + 4'h1;
            end
          end
        end
        RLP_RUN: begin
          if (tick && count_reg == `RLP_CNT_LAST) begin
            state_reg    <= RLP_LOAD;
            load_idx_reg <= 4'h0;
            if (com_reg == (ctrl_reg.com_four ? 2'h3 : 2'h2)) begin
              com_reg       <= 2'h0;
              frame_buf_reg <= ctrl_reg.buf_sel;
            end else begin
              com_reg <= com_reg + 2'h1;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Duty registers: software writes, or hardware loads while scanning.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < `RLP_NUM_CH; i++) begin
        duty_reg[i] <= `RLP_DUTY_RESET;
      end
    end else if (scanning) begin
      if (in_load && tick && load_tick_reg == 2'(`RLP_LOAD_TICKS - 1)) begin
        duty_reg[load_idx_reg] <= load_byte;
      end
    end else if (wr_pend_reg && wr_addr_reg >= `RLP_ADDR_DUTY0 &&
                 wr_addr_reg < `RLP_ADDR_DUTY0 + 12'(4 * `RLP_NUM_CH)) begin
      duty_reg[4'((wr_addr_reg - `RLP_ADDR_DUTY0) >> 2)] <= hwdata[7:0];
    end
  end

  // ==========================================================
  // Outputs, registered. Channels are low while lit.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      led_channel_outputs <= 15'h7fff;
      led_channel_oe_n    <= 15'h0000;
      common_drive_lines  <= 4'hf;
    end else begin
      for (int i = 0; i < `RLP_NUM_CH; i++) begin
        led_channel_outputs[i] <= !(ctrl_reg.enable && !in_load &&
                                    count_reg < duty_reg[i]);
        led_channel_oe_n[i]    <= scanning && i >= `RLP_SCAN_CH;
      end
      for (int m = 0; m < `RLP_NUM_COM; m++) begin
        if (scanning && state_reg == RLP_RUN && com_reg == 2'(m)) begin
          common_drive_lines[m] <= ctrl_reg.polarity;
        end else begin
          common_drive_lines[m] <= !ctrl_reg.polarity;
        end
      end
    end
  end
endmodule : rlp_pwm_control

// ### tb/rlp_led_model.sv
`timescale 1ns/1ps
// ==========================================
// LED array behind scanned common lines
module rlp_led_model (
  // Clock and control
  input  wire logic        clock,
  input  wire logic        clear,
  input  wire logic        active_high,
  input  wire logic [3:0]  probe,
  // Pins
  input  wire logic [14:0] led_channel_outputs,
  input  wire logic [14:0] led_channel_oe_n,
  input  wire logic [3:0]  common_drive_lines,
  // Observations
  output logic [15:0]      lit_count,
  output logic [3:0]       com_seen
);
  // A channel lights only while it is driven and pulled low.
  always_ff @(posedge clock) begin
    if (clear) begin
      lit_count <= 16'h0000;
      com_seen  <= 4'h0;
    end else begin
      lit_count <= lit_count + 16'(!led_channel_oe_n[probe] && !led_channel_outputs[probe]);
      com_seen  <= com_seen | (active_high ? common_drive_lines : ~common_drive_lines);
    end
  end
endmodule : rlp_led_model

// ### tb/rlp_pwm_control_chk.sv
`timescale 1ns/1ps
// ==========================================
// Port-level checker for the PWM control block
module rlp_pwm_control_chk (
  // Clock and reset
  input wire logic        clock,
  input wire logic        reset,
  // Bus
  input wire logic        hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  // Pins
  input wire logic [14:0] led_channel_outputs,
  input wire logic [14:0] led_channel_oe_n,
  input wire logic [3:0]  common_drive_lines,
  input wire logic        pwm_clock
);
  logic [7:0] ctl;
  logic       wr_q;
  logic       rd_q;
  logic [1:0] qc;
  wire        go  = hsel && hready && htrans[1] && haddr == 12'h000;
  // Pins are judged only once a control write has had three cycles to land.
  wire        ok  = qc == 2'h3;
  wire [3:0]  off = {4{~ctl[2]}};
  wire        scn = ok && ctl[7] && ctl[0];
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      {wr_q, rd_q, ctl, qc} <= '0;
    end else begin
      wr_q <= go && hwrite;
      rd_q <= go && !hwrite;
      qc   <= wr_q ? 2'h0 : (ok ? qc : qc + 2'h1);
      if (wr_q)
        ctl <= ctl[7] ? {hwdata[7], ctl[6:4], hwdata[3], ctl[2:0]} : hwdata[7:0];
    end
  end
  a_off_channels: assert property (ok && !ctl[7] |-> led_channel_outputs[11:0] == 12'hfff)
    else $error("Channels not parked high while disabled.");
  a_off_commons: assert property (ok && !ctl[7] |-> common_drive_lines == off)
    else $error("Commons not inactive while disabled.");
  a_direct_commons: assert property (ok && ctl[7] && !ctl[0] |-> common_drive_lines == off)
    else $error("Commons active in direct mode.");
  a_scan_single: assert property (scn |-> $onehot0(common_drive_lines ^ off))
    else $error("More than one common active.");
  a_scan_three: assert property (scn && !ctl[1] |-> common_drive_lines[3] == off[3])
    else $error("Fourth common used in three-line scan.");
  a_scan_float: assert property (scn |-> led_channel_oe_n[14:12] == 3'h7)
    else $error("Upper channels driven while scanning.");
  a_bit_six: assert property (rd_q |-> hrdata[6] == 1'b0)
    else $error("Control bit 6 read as one.");
  a_div_three: assert property (ok && ctl[7] && ctl[5:4] == 2'h2 && $rose(pwm_clock)
    |=> pwm_clock ##1 !pwm_clock ##1 pwm_clock) else $error("Divide by three shape wrong.");
endmodule : rlp_pwm_control_chk
bind rlp_pwm_control rlp_pwm_control_chk rlp_pwm_control_chk_i (
  .clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .led_channel_outputs(led_channel_outputs), .led_channel_oe_n(led_channel_oe_n),
  .common_drive_lines(common_drive_lines), .pwm_clock(pwm_clock));

// ### tb/testbench.sv
`timescale 1ns/1ps
// ==========================================
// Register and pin tests of the PWM control block
module testbench;
  import rlp_pkg::*;
  logic        clock = 0, reset = 1, hsel = 0, hwrite = 0, clear = 1, hi = 0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic [3:0]  probe = 4'h0, com_seen, com;
  logic [14:0] led, oe_n;
  logic [15:0] lit, lit_got;
  wire         hready, resp;
  int          n_mismatch = 0, check_count = 0, cycles = 0;
  always #2 clock = ~clock;
  rlp_pwm_control rlp_pwm_control_i (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hready), .hresp(resp), .led_channel_outputs(led),
    .led_channel_oe_n(oe_n), .common_drive_lines(com), .pwm_clock());
  rlp_led_model rlp_led_model_i (.clock(clock), .clear(clear), .active_high(hi), .probe(probe),
    .led_channel_outputs(led), .led_channel_oe_n(oe_n), .common_drive_lines(com),
    .lit_count(lit), .com_seen(com_seen));
  task automatic check_val(input string what, input logic [31:0] exp, got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    hsel <= 1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic rchk(input string what, input logic [11:0] a, input logic [7:0] e);
    xfer(0, a, 8'h00);
    check_val(what, {24'h0, e}, rd);
  endtask : rchk
  // Counts over exactly n cycles, so any whole period gives the same total.
  // The total is taken at a falling edge, where it has settled, then the bench resyncs.
  task automatic measure(input logic [3:0] ch, input int n, output logic [15:0] got);
    probe <= ch;
    clear <= 1;
    @(posedge clock);
    clear <= 0;
    repeat (n) @(posedge clock);
    @(negedge clock);
    got = lit;
    @(posedge clock);
  endtask : measure
  task automatic conclude;
    $display("Mismatches %0d in %0d checks", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    repeat (6) @(posedge clock);
    reset <= 0;
    rchk("ctrl", 12'h000, 8'h00);
    for (int i = 0; i < 15; i++) rchk("duty", 12'h004 + 12'(4 * i), 8'h00);
    rchk("status", 12'h040, 8'h00);
    check_val("hresp", 32'h0, {31'h0, resp});
    check_val("commons", 32'hf, {28'h0, com});
    check_val("channels", 32'hfff, {20'h0, led[11:0]});
    xfer(1, 12'h000, 8'h46);
    rchk("ctrl", 12'h000, 8'h06);
    repeat (3) @(posedge clock);
    check_val("commons", 32'h0, {28'h0, com});
    xfer(1, 12'h000, 8'h00);
    for (int i = 0; i < 15; i++) xfer(1, 12'h004 + 12'(4 * i), 8'(17 * i));
    for (int i = 0; i < 15; i++) rchk("duty", 12'h004 + 12'(4 * i), 8'(17 * i));
    $display("Test registers done");
    for (int c = 0; c < 4; c++) begin
      xfer(1, 12'h000, {2'b10, 2'(c), 4'h0});
      repeat (8) @(posedge clock);
      measure(4'h5, 256 * (c + 1), lit_got);
      check_val("lit", 32'(85 * (c + 1)), {16'h0, lit_got});
      check_val("commons", 32'hf, {28'h0, com});
      xfer(1, 12'h000, 8'h00);
    end
    xfer(1, 12'h000, 8'h80);
    xfer(1, 12'h018, 8'h20);
    // Enabled two edges ago: a duty write that restarted the period would read zero here.
    rchk("status", 12'h040, 8'h02);
    measure(4'h5, 256, lit_got);
    check_val("lit", 32'h20, {16'h0, lit_got});
    xfer(1, 12'h000, 8'h8f);
    rchk("ctrl", 12'h000, 8'h88);
    xfer(1, 12'h000, 8'h00);
    $display("Test direct drive done");
    for (int i = 0; i < 48; i++) xfer(1, 12'h100 + 12'(4 * i), 8'h21);
    for (int i = 0; i < 48; i++) xfer(1, 12'h200 + 12'(4 * i), 8'h42);
    // The first pass scans three active-high commons, the second four active-low ones.
    for (int n = 0; n < 2; n++) begin
      xfer(1, 12'h000, {5'h00, !n[0], n[0], 1'b1});
      xfer(1, 12'h000, {5'h10, !n[0], n[0], 1'b1});
      hi <= !n[0];
      measure(4'h0, 1400, lit_got);
      check_val("commons seen", n ? 32'hf : 32'h7, {28'h0, com_seen});
      rchk("duty", 12'h004, 8'h21);
      xfer(1, 12'h004, 8'haa);
      rchk("duty", 12'h004, 8'h21);
      rchk("buffer a", 12'h100, 8'h00);
      rchk("buffer b", 12'h200, 8'h42);
      check_val("float", 32'h7, {29'h0, oe_n[14:12]});
      xfer(1, 12'h000, 8'h00);
    end
    xfer(1, 12'h000, 8'h87);
    repeat (300) @(posedge clock);
    xfer(1, 12'h000, 8'h8f);
    // Past duty 0 of the second common's load, which an early buffer switch would fill from B.
    repeat (30) @(posedge clock);
    rchk("duty", 12'h004, 8'h21);
    repeat (2600) @(posedge clock);
    rchk("duty", 12'h004, 8'h42);
    rchk("buffer a", 12'h100, 8'h21);
    rchk("buffer b", 12'h200, 8'h00);
    $display("Test scanning done");
    conclude();
  end
endmodule : testbench
